// File: spg_gpio.sv
// Shared-pin GPIO for ports A and B
module spg_gpio (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// CPU data bus
	input  wire spg_pkg::spg_bus_t bus,
	output logic [15:0]           rdata,
	// Port pads
	input  wire logic [7:0]       port_a_pin_in,
	output spg_pkg::spg_pad_t     port_a_pad,
	input  wire logic [7:0]       port_b_pin_in,
	output spg_pkg::spg_pad_t     port_b_pad,
	// Peripheral functions
	input  wire logic [7:0]       port_a_periph_out,
	input  wire logic [7:0]       port_a_periph_oe,
	input  wire logic [7:0]       port_b_periph_out,
	input  wire logic [7:0]       port_b_periph_oe,
	output logic [7:0]            port_a_periph_in,
	output logic [7:0]            port_b_periph_in,
	output logic                  drive_fault_input
);
	logic [15:0] func_sel_reg, func_sel_next;
	logic [15:0] pa_reg, pa_next, pb_reg, pb_next;
	logic [15:0] rdata_reg, rdata_next;
	logic        fault_reg, fault_next;
	logic [7:0]  pa_level, pb_level, pa_pin, pb_pin;

	spg_port u_port_a (
		.clk        (clk),
		.nrst       (nrst),
		.func_sel   (func_sel_reg[7:0]),                             // [RL6]
		.datdir     (pa_reg),
		.pin_in     (port_a_pin_in),
		.pin_out    (port_a_pad.out),
		.pin_oe     (port_a_pad.oe),
		.periph_out (port_a_periph_out),
		.periph_oe  (port_a_periph_oe),
		.periph_in  (pa_pin),
		.pin_level  (pa_level)
	);

	spg_port u_port_b (
		.clk        (clk),
		.nrst       (nrst),
		.func_sel   (func_sel_reg[15:8]),                            // [RL6]
		.datdir     (pb_reg),
		.pin_in     (port_b_pin_in),
		.pin_out    (port_b_pad.out),
		.pin_oe     (port_b_pad.oe),
		.periph_in  (pb_pin),
		.periph_out (port_b_periph_out),
		.periph_oe  (port_b_periph_oe),
		.pin_level  (pb_level)
	);

	// Register writes and read mux; unmapped reads give zero
	always_comb begin
		func_sel_next = func_sel_reg;
		pa_next       = pa_reg;
		pb_next       = pb_reg;
		rdata_next    = rdata_reg;
		fault_next    = pa_pin[spg_pkg::FAULT_PIN];                     // [RL7]
		if (bus.wr) begin
			if (bus.addr == spg_pkg::ADDR_FUNC_SEL) begin           // [RL9] [RL8]
				func_sel_next = bus.wdata;
			end else if (bus.addr == spg_pkg::ADDR_PORT_A) begin
				pa_next = bus.wdata;
			end else if (bus.addr == spg_pkg::ADDR_PORT_B) begin
				pb_next = bus.wdata;
			end
		end
		if (bus.rd) begin
			if (bus.addr == spg_pkg::ADDR_FUNC_SEL) begin
				rdata_next = func_sel_reg;
			end else if (bus.addr == spg_pkg::ADDR_PORT_A) begin
				rdata_next = {pa_reg[15:8], pa_level};               // [RL11] [RL3]
			end else if (bus.addr == spg_pkg::ADDR_PORT_B) begin
				rdata_next = {pb_reg[15:8], pb_level};
			end else begin
				rdata_next = 16'h0000;
			end
		end
	end

	// Reset puts every pin in I/O input mode
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			func_sel_reg <= spg_pkg::RST_FUNC_SEL;                     // [RL10]
			pa_reg       <= spg_pkg::RST_PORT;
			pb_reg       <= spg_pkg::RST_PORT;
			rdata_reg    <= 16'h0000;
			fault_reg    <= 1'b0;
		end else begin
			func_sel_reg <= func_sel_next;
			pa_reg       <= pa_next;
			pb_reg       <= pb_next;
			rdata_reg    <= rdata_next;
			fault_reg    <= fault_next;
		end
	end

	assign rdata             = rdata_reg;
	assign drive_fault_input = fault_reg;
	assign port_a_periph_in  = pa_pin;
	assign port_b_periph_in  = pb_pin;

	// Port A pin 1 as I/O output: pad driven with the data bit
	AST_IO_OUT: assert property (@(posedge clk) disable iff (!nrst)
		(!func_sel_reg[1] && pa_reg[9]) |=> port_a_pad.oe[1] == 1'b1 && port_a_pad.out[1] == $past(pa_reg[1]))
		else $error("I/O output pin not driven");                   // [RL2]

	// Port B pin 1 as I/O output, same path on the other port
	AST_IO_OUT_B: assert property (@(posedge clk) disable iff (!nrst)
		(!func_sel_reg[9] && pb_reg[9]) |=> port_b_pad.oe[1] == 1'b1 && port_b_pad.out[1] == $past(pb_reg[1]))
		else $error("Port B output pin not driven");                // [RL2] [RL3]

	// Port B pin 0 as I/O input: pad released
	AST_IO_IN: assert property (@(posedge clk) disable iff (!nrst)
		(!func_sel_reg[8] && !pb_reg[8]) |=> !port_b_pad.oe[0])
		else $error("I/O input pin driven");                        // [RL2]

	// Port A pin 5 as I/O input: pad released
	AST_IO_IN_A: assert property (@(posedge clk) disable iff (!nrst)
		(!func_sel_reg[5] && !pa_reg[13]) |=> !port_a_pad.oe[5])
		else $error("Port A input pin driven");                     // [RL2]

	// Peripheral drive reaches the pad when selected
	AST_PERIPH: assert property (@(posedge clk) disable iff (!nrst)
		func_sel_reg[3] |=> port_a_pad.out[3] == $past(port_a_periph_out[3]))
		else $error("Peripheral not routed");                       // [RL1]

	// Same on port B, serial transmit position
	AST_PERIPH_B: assert property (@(posedge clk) disable iff (!nrst)
		func_sel_reg[11] |=> port_b_pad.out[3] == $past(port_b_periph_out[3]))
		else $error("Port B peripheral not routed");                // [RL1]

	// Peripheral enable, not the direction bit, steers the pad
	AST_PERIPH_OE: assert property (@(posedge clk) disable iff (!nrst)
		func_sel_reg[6] |=> port_a_pad.oe[6] == $past(port_a_periph_oe[6]))
		else $error("Peripheral enable not routed");                // [RL1]

	// Direction bit must not turn on a peripheral-owned pad
	AST_IGNORE: assert property (@(posedge clk) disable iff (!nrst)
		(func_sel_reg[12] && !port_b_periph_oe[4]) |=> !port_b_pad.oe[4])
		else $error("Direction bit leaked in peripheral mode");     // [RL4]

	// Data bit must not override peripheral drive
	AST_IGNORE_A: assert property (@(posedge clk) disable iff (!nrst)
		(func_sel_reg[2] && !pa_reg[2] && port_a_periph_out[2]) |=> port_a_pad.out[2])
		else $error("Data bit leaked in peripheral mode");          // [RL4]

	// Direction half of port A reads back as stored
	AST_READ_A: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == spg_pkg::ADDR_PORT_A) |=> rdata[15:8] == $past(pa_reg[15:8]))
		else $error("Port A direction readback wrong");             // [RL5]

	// Direction half of port B reads back as stored
	AST_READ_B: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == spg_pkg::ADDR_PORT_B) |=> rdata[15:8] == $past(pb_reg[15:8]))
		else $error("Port B direction readback wrong");             // [RL5]

	// Data half is the pad level two flops back, plus the read flop
	AST_SYNC: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == spg_pkg::ADDR_PORT_B) |=> rdata[7:0] == $past(port_b_pin_in, 3))
		else $error("Port B data read not synchronised level");     // [RL11]

	// Same latency on port A
	AST_SYNC_A: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == spg_pkg::ADDR_PORT_A) |=> rdata[7:0] == $past(port_a_pin_in, 3))
		else $error("Port A data read not synchronised level");     // [RL3] [RL11]

	// Select register reads back whole
	AST_FSEL_RD: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == spg_pkg::ADDR_FUNC_SEL) |=> rdata == $past(func_sel_reg))
		else $error("Select readback wrong");                       // [RL9]

	// Select write lands one cycle on
	AST_FSEL_WR: assert property (@(posedge clk) disable iff (!nrst)
		(bus.wr && bus.addr == spg_pkg::ADDR_FUNC_SEL) |=> func_sel_reg == $past(bus.wdata))
		else $error("Select write lost");                           // [RL9]

	// Port A write lands one cycle on
	AST_PA_WR: assert property (@(posedge clk) disable iff (!nrst)
		(bus.wr && bus.addr == spg_pkg::ADDR_PORT_A) |=> pa_reg == $past(bus.wdata))
		else $error("Port A write lost");                           // [RL8] [RL9]

	// Port B write lands one cycle on
	AST_PB_WR: assert property (@(posedge clk) disable iff (!nrst)
		(bus.wr && bus.addr == spg_pkg::ADDR_PORT_B) |=> pb_reg == $past(bus.wdata))
		else $error("Port B write lost");                           // [RL8] [RL9]

	// Reads outside the three registers answer zero
	AST_UNMAPPED: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr != spg_pkg::ADDR_FUNC_SEL && bus.addr != spg_pkg::ADDR_PORT_A
			&& bus.addr != spg_pkg::ADDR_PORT_B) |=> rdata == 16'h0000)
		else $error("Unmapped read not zero");                      // [RL9]

	// Read data holds between reads so software can take it late
	AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!nrst)
		!bus.rd |=> $stable(rdata))
		else $error("Read data changed without a read");            // [RL9]

	// Peripherals see the synchronised pad level; wait for the flops to fill
	AST_PERIPH_IN: assert property (@(posedge clk) disable iff (!nrst)
		$past(nrst, 3) |-> port_a_periph_in == $past(port_a_pin_in, 2))
		else $error("Peripheral input not synchronised level");     // [RL11]

	// Fault path: two sync flops and one output flop, checked with port A pin 0 in I/O mode
	AST_FAULT: assert property (@(posedge clk) disable iff (!nrst)
		!func_sel_reg[0] |-> ##4 drive_fault_input == $past(port_a_pin_in[0], 3))
		else $error("Fault input not active in I/O mode");          // [RL7]
endmodule

// File: spg_gpio_tb.sv
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module spg_gpio_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clk, nrst, flt;
	spg_pkg::spg_bus_t bus;
	logic [15:0]       rdata;
	spg_pkg::spg_pad_t pa, pb;
	logic [7:0]        ea, eb, pia, pib, poa, pea, pob, peb, fia, fib;
	int                errors, compares;

	spg_gpio u_dut (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .port_a_pin_in(pia), .port_a_pad(pa),
		.port_b_pin_in(pib), .port_b_pad(pb), .port_a_periph_out(poa), .port_a_periph_oe(pea),
		.port_b_periph_out(pob), .port_b_periph_oe(peb), .port_a_periph_in(fia), .port_b_periph_in(fib),
		.drive_fault_input(flt));
	spg_pads u_pads_a (.pad(pa), .ext(ea), .pin(pia));
	spg_pads u_pads_b (.pad(pb), .ext(eb), .pin(pib));

	// Clock at 40 ns
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Write, then leave time for pads and the input synchroniser to settle
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		bus = '{1'b0, 1'b1, a, d};
		@(negedge clk);
		bus.wr = 1'b0;
		repeat (4) @(negedge clk);
	endtask

	// Read strobe for one cycle, data checked once it has landed
	task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
		@(negedge clk);
		bus = '{1'b1, 1'b0, a, 16'h0000};
		@(negedge clk);
		bus.rd = 1'b0;
		`CHK(n, e, rdata)
	endtask

	task automatic summarize;
		if (errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		nrst = 1'b0;
		bus = '0;
		ea = 8'hA5;
		eb = 8'h3C;
		poa = 8'hAA;
		pea = 8'hF0;
		pob = 8'h55;
		peb = 8'hFF;
		errors = 0;
		compares = 0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		`CHK("oe_a", 8'h00, pa.oe)
		rd(16'h7090, 16'h0000, "sel_rst");
		rd(16'h7098, 16'h00A5, "pa_rst");
		rd(16'h709A, 16'h003C, "pb_rst");
		`CHK("fia", 8'hA5, fia)
		`CHK("fib", 8'h3C, fib)
		wr(16'h7098, 16'hFF0F);
		`CHK("oe_a_io", 8'hFF, pa.oe)
		`CHK("out_a_io", 8'h0F, pa.out)
		rd(16'h7098, 16'hFF0F, "pa_back");
		// Upper half of port A handed to its peripheral
		wr(16'h7090, 16'h00F0);
		`CHK("oe_a_mix", 8'hFF, pa.oe)
		`CHK("out_a_mix", 8'hAF, pa.out)
		wr(16'h709A, 16'hFF55);
		`CHK("out_b_io", 8'h55, pb.out)
		`CHK("oe_b_io", 8'hFF, pb.oe)
		pob = 8'h0F;
		wr(16'h7090, 16'hFF00);
		`CHK("out_b_per", 8'h0F, pb.out)
		`CHK("oe_b_per", 8'hFF, pb.oe)
		`CHK("out_a_back", 8'h0F, pa.out)
		// Unmapped place neither stores nor answers
		wr(16'h7092, 16'hFFFF);
		rd(16'h7092, 16'h0000, "unmapped");
		rd(16'h7090, 16'hFF00, "sel_keep");
		// Fault input still seen while its pin is plain I/O
		wr(16'h7098, 16'h0000);
		ea = 8'h01;
		repeat (5) @(negedge clk);
		`CHK("fault_hi", 1'b1, flt)
		ea = 8'h00;
		repeat (5) @(negedge clk);
		`CHK("fault_lo", 1'b0, flt)
		summarize();
	end
endmodule

// File: spg_pads.sv
// Outside world of one 8-pin port: pad level seen by the block
module spg_pads (
	// Pad drive from the block
	input  wire spg_pkg::spg_pad_t pad,
	// Level forced from outside on released pins
	input  wire logic [7:0]        ext,
	// Level back into the block
	output logic [7:0]             pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// A driven pin shows its own value, so a read-back of an output pin
	// shows that value once it has passed the two sync flops
	assign pin = (pad.oe & pad.out) | (~pad.oe & ext);
endmodule

// File: spg_pkg.sv
// What this block does
// [RL1] Function-select bit 1 routes pin to peripheral, 0 to general-purpose I/O.
// [RL2] In I/O mode, direction 0 makes an input, 1 drives an output.
// [RL3] Input pins read sampled level; output pins drive the written data bit.
// [RL4] Peripheral mode ignores the pin's data and direction bits.
// [RL5] Port register: data bits 0-7, direction bits 8-15.
// [RL6] Select register: port A pins bits 0-7, port B pins bits 8-15.
// [RL7] Drive fault input stays active even when its pin is I/O.
// [RL8] All pin control lives in 16-bit select and data/direction registers.
// [RL9] Registers mapped at fixed data-space addresses 7090h, 7098h, 709Ah.
// [RL10] Reset clears all select and direction bits: I/O inputs.
// [RL11] Data reads return synchronised pin level, also for outputs.
package spg_pkg;
	localparam logic [15:0] ADDR_FUNC_SEL = 16'h7090;
	localparam logic [15:0] ADDR_PORT_A   = 16'h7098;
	localparam logic [15:0] ADDR_PORT_B   = 16'h709A;
	localparam logic [15:0] RST_FUNC_SEL  = 16'h0000;
	localparam logic [15:0] RST_PORT      = 16'h0000;
	localparam int          DATA_LSB      = 0;
	localparam int          DIR_LSB       = 8;
	localparam int          PORT_B_LSB    = 8;
	localparam int          FAULT_PIN     = 0;

	// CPU data-space access
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} spg_bus_t;

	// One 8-bit port as seen by the pads
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} spg_pad_t;
endpackage

// File: spg_port.sv
// One 8-pin port: sync, mux between peripheral and I/O
module spg_port (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Control
	input  wire logic [7:0] func_sel,
	input  wire logic [15:0] datdir,
	// Pads
	input  wire logic [7:0] pin_in,
	output logic [7:0]      pin_out,
	output logic [7:0]      pin_oe,
	// Peripheral side
	input  wire logic [7:0] periph_out,
	input  wire logic [7:0] periph_oe,
	output logic [7:0]      periph_in,
	output logic [7:0]      pin_level
);
	logic [7:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
	logic [7:0] out_reg, out_next, oe_reg, oe_next;

	// Pad output mux; data/dir are don't-care in peripheral mode
	always_comb begin
		sync1_next = pin_in;
		sync2_next = sync1_reg;
		for (int i = 0; i < 8; i++) begin
			if (func_sel[i]) begin                                   // [RL1] [RL4]
				out_next[i] = periph_out[i];
				oe_next[i]  = periph_oe[i];
			end else begin
				out_next[i] = datdir[spg_pkg::DATA_LSB + i];          // [RL3] [RL5]
				oe_next[i]  = datdir[spg_pkg::DIR_LSB + i];           // [RL2] [RL5]
			end
		end
	end

	// Two-stage sync keeps metastability away from software reads
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
			out_reg   <= 8'h00;
			oe_reg    <= 8'h00;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;                                   // [RL11]
			out_reg   <= out_next;
			oe_reg    <= oe_next;
		end
	end

	assign pin_out   = out_reg;
	assign pin_oe    = oe_reg;
	assign periph_in = sync2_reg;
	assign pin_level = sync2_reg;
endmodule
